// [adc_result_formatter.sv]
// conversion result formatter: apb register slave, repeat series control and
// the published 16-bit result pair
// assumes conv.valid pulses for one cycle per finished conversion, synchronous
// to pclk; the apb master follows the usual setup/access sequence
`timescale 1ns/10ps

module adc_result_formatter
    import adc_fmt_pkg::*;
(
    input wire logic pclk, // system clock, 40 MHz
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire conv_sample_t conv, // finished conversion from the core
    output result_pair_t result, // published result pair
    output logic result_update // high for one cycle per published result, even when the value is unchanged
);

    typedef enum logic [0:0] {ST_FIRST, ST_MIDDLE} series_state_t;

    function automatic logic addr_known(input logic [ADDR_W-1:0] addr);
        addr_known = (addr == ADDR_CTRL) || (addr == ADDR_CFG) ||
            (addr == ADDR_RES_LOW) || (addr == ADDR_RES_HIGH) ||
            (addr == ADDR_STATUS);
    endfunction

    // apb decode
    logic apb_setup;
    logic apb_access;
    logic apb_wr;
    logic ctrl_wr;
    logic cfg_wr;

    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign apb_wr = apb_access && pwrite;
    assign ctrl_wr = apb_wr && (paddr == ADDR_CTRL);
    assign cfg_wr = apb_wr && (paddr == ADDR_CFG);

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_known(paddr);

    // software registers
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic left_justify_select;
    logic [1:0] repeat_count_field;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        cfg_next = cfg_reg;
        if (ctrl_wr)
        begin
            ctrl_next = pwdata[7:0];
        end
        if (cfg_wr)
        begin
            cfg_next = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RESET;
            cfg_reg <= CFG_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            cfg_reg <= cfg_next;
        end
    end

    assign left_justify_select = ctrl_reg[CTRL_LJST_BIT];
    assign repeat_count_field = cfg_reg[CFG_RPT_LSB +: 2];

    // series tracking
    series_state_t state_reg;
    series_state_t state_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] series_total;
    logic series_last;
    logic single_mode;
    logic acc_load;
    logic acc_add;
    logic misuse;

    assign series_total = rpt_total(repeat_count_field);
    assign series_last = (count_reg == CNT_W'(series_total - 5'h01));
    assign single_mode = (repeat_count_field == RPT_ONE);
    // left justify with a repeat count is a software fault; the sum stays right-justified
    assign misuse = left_justify_select && !single_mode;

    // a sample in the same cycle as a config write is dropped with the old series
    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        acc_load = 1'b0;
        acc_add = 1'b0;
        if (cfg_wr)
        begin
            state_next = ST_FIRST;
            count_next = '0;
        end
        else if (conv.valid)
        begin
            case (state_reg)
                ST_FIRST:
                begin
                    acc_load = 1'b1;
                    if (series_last)
                    begin
                        count_next = '0;
                    end
                    else
                    begin
                        state_next = ST_MIDDLE;
                        count_next = 5'h01;
                    end
                end
                ST_MIDDLE:
                begin
                    acc_add = 1'b1;
                    if (series_last)
                    begin
                        state_next = ST_FIRST;
                        count_next = '0;
                    end
                    else
                    begin
                        count_next = CNT_W'(count_reg + 5'h01);
                    end
                end
                default:
                begin
                    state_next = ST_FIRST;
                    count_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_FIRST;
            count_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    logic [RESULT_W-1:0] acc_sum;
    logic [RESULT_W-1:0] acc_sum_next;
    logic [RESULT_W-1:0] just_word;

    sample_accumulator u_acc (
        .pclk(pclk),
        .presetn(presetn),
        .load(acc_load),
        .add(acc_add),
        .code(conv.code),
        .sum(acc_sum),
        .sum_next(acc_sum_next)
    );

    result_justify u_just (
        .code(conv.code),
        .left(left_justify_select),
        .word(just_word)
    );

    // published result
    logic [RESULT_W-1:0] result_reg;
    logic [RESULT_W-1:0] result_next;
    logic update_reg;
    logic update_next;

    always_comb
    begin
        result_next = result_reg;
        update_next = 1'b0;
        if (conv.valid && series_last && !cfg_wr)
        begin
            update_next = 1'b1;
            if (single_mode)
            begin
                result_next = just_word;
            end
            else
            begin
                result_next = acc_sum_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_reg <= RESULT_RESET;
            update_reg <= 1'b0;
        end
        else
        begin
            result_reg <= result_next;
            update_reg <= update_next;
        end
    end

    assign result = result_pair_t'(result_reg);
    assign result_update = update_reg;

    // read data is captured in the setup cycle, so a result published on the
    // access edge is seen by the next read
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [31:0] status_word;

    always_comb
    begin
        status_word = '0;
        status_word[CNT_W-1:0] = count_reg;
        status_word[STAT_ACTIVE_BIT] = (state_reg == ST_MIDDLE);
        status_word[STAT_MISUSE_BIT] = misuse;
    end

    always_comb
    begin
        prdata_next = prdata_reg;
        if (apb_setup && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL: prdata_next = {24'h000000, ctrl_reg};
                ADDR_CFG: prdata_next = {24'h000000, cfg_reg};
                ADDR_RES_LOW: prdata_next = {24'h000000, result.low};
                ADDR_RES_HIGH: prdata_next = {24'h000000, result.high};
                ADDR_STATUS: prdata_next = status_word;
                default: prdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // helper for checks: every sample of the running series at full scale
    logic full_run_reg;
    logic full_now;

    always_comb
    begin
        full_now = (conv.code == 12'hFFF) &&
            ((state_reg == ST_FIRST) || full_run_reg);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            full_run_reg <= 1'b0;
        end
        else if (conv.valid)
        begin
            full_run_reg <= full_now;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking

    default disable iff (!presetn);

    a_high_byte_read:
    assert property (apb_setup && !pwrite && paddr == ADDR_RES_HIGH
        |=> prdata == {24'h000000, $past(result_reg[15:8])})
    else $error("high result byte read back wrong");

    a_single_refresh:
    // a second back-to-back sample legitimately keeps the pulse up
    assert property (conv.valid && single_mode && !cfg_wr
        |=> result_update ##1 (!result_update || $past(conv.valid)))
    else $error("single conversion did not refresh result once");

    a_right_place:
    assert property (conv.valid && single_mode && !left_justify_select && !cfg_wr
        |=> result_reg == {4'h0, $past(conv.code)})
    else $error("right-justified code misplaced");

    a_left_place:
    assert property (conv.valid && single_mode && left_justify_select && !cfg_wr
        |=> result_reg == {$past(conv.code), 4'h0})
    else $error("left-justified code misplaced");

    a_unused_zero:
    assert property (conv.valid && single_mode && !cfg_wr
        |=> ($past(left_justify_select) ? (result_reg[3:0] == 4'h0) :
            (result_reg[15:12] == 4'h0)))
    else $error("unused result bits not zero");

    a_hold_mid_series:
    assert property (!(conv.valid && series_last)
        |=> $stable(result_reg) && !result_update)
    else $error("result changed before series end");

    a_count_bound:
    assert property (count_reg < series_total)
    else $error("series count beyond repeat field");

    a_fresh_series:
    assert property (conv.valid && state_reg == ST_FIRST && !cfg_wr
        |=> acc_sum == {4'h0, $past(conv.code)})
    else $error("accumulator not cleared at series start");

    a_full_scale_sum:
    assert property (conv.valid && series_last && full_now && !cfg_wr && !single_mode
        |=> result_reg == ($past(repeat_count_field) == RPT_FOUR ? 16'h3FFC :
            $past(repeat_count_field) == RPT_EIGHT ? 16'h7FF8 : 16'hFFF0))
    else $error("full scale series sum wrong");

    a_sum_published:
    assert property (conv.valid && series_last && !cfg_wr && !single_mode
        |=> result_reg == $past(acc_sum_next) && result_update)
    else $error("series sum not published");

    c_single_right: cover property (conv.valid && single_mode && !left_justify_select);
    c_single_left: cover property (conv.valid && single_mode && left_justify_select);
    c_series_four: cover property (result_update && $past(repeat_count_field) == RPT_FOUR);
    c_series_sixteen: cover property (conv.valid && series_last && series_total == 5'h10);
    c_restart_mid: cover property (cfg_wr && state_reg == ST_MIDDLE);

endmodule

// [adc_fmt_pkg.sv]
// constants, field layout and carrier types for the conversion result formatter
// assumes a 12-bit converter core that hands over one code per completed conversion
package adc_fmt_pkg;

    localparam int SAMPLE_W = 12;
    localparam int RESULT_W = 16;
    localparam int CNT_W = 5;
    localparam int ADDR_W = 8;

    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_RES_LOW = 8'h08;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // converter_control_reg and converter_config_reg fields
    localparam int CTRL_LJST_BIT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CFG_RPT_LSB = 1;
    localparam logic [7:0] CFG_RESET = 8'hF8;

    // repeat_count_field encodings
    localparam logic [1:0] RPT_ONE = 2'h0;
    localparam logic [1:0] RPT_FOUR = 2'h1;
    localparam logic [1:0] RPT_EIGHT = 2'h2;
    localparam logic [1:0] RPT_SIXTEEN = 2'h3;

    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // status word layout
    localparam int STAT_ACTIVE_BIT = 8;
    localparam int STAT_MISUSE_BIT = 9;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] code;
    } conv_sample_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } result_pair_t;

    function automatic logic [CNT_W-1:0] rpt_total(input logic [1:0] rpt);
        case (rpt)
            RPT_FOUR: rpt_total = 5'h04;
            RPT_EIGHT: rpt_total = 5'h08;
            RPT_SIXTEEN: rpt_total = 5'h10;
            default: rpt_total = 5'h01;
        endcase
    endfunction

endpackage

// [result_justify.sv]
// places a single 12-bit code right- or left-justified in the 16-bit result word
// purely combinational; the caller registers the outcome
`timescale 1ns/10ps

module result_justify
    import adc_fmt_pkg::*;
(
    input wire logic [SAMPLE_W-1:0] code, // raw converter code
    input wire logic left, // high selects left-justified placement
    output logic [RESULT_W-1:0] word // formatted result word
);

    localparam int PAD_W = RESULT_W - SAMPLE_W;

    always_comb
    begin
        if (left)
        begin
            word = {code, {PAD_W{1'b0}}};
        end
        else
        begin
            word = {{PAD_W{1'b0}}, code};
        end
    end

endmodule

// [sample_accumulator.sv]
// running sum of converter codes for one repeat series
// load starts a fresh sum, add extends it; never both in one cycle
`timescale 1ns/10ps

module sample_accumulator
    import adc_fmt_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic load, // first sample of a series
    input wire logic add, // later sample of a series
    input wire logic [SAMPLE_W-1:0] code, // sample to take in
    output logic [RESULT_W-1:0] sum, // sum so far
    output logic [RESULT_W-1:0] sum_next // sum including this cycle's sample
);

    logic [RESULT_W-1:0] sum_reg;
    logic [RESULT_W-1:0] code_ext;

    assign code_ext = {{(RESULT_W-SAMPLE_W){1'b0}}, code};

    // sixteen full-scale codes reach 0xFFF0, so 16 bits never wrap
    always_comb
    begin
        sum_next = sum_reg;
        if (load)
        begin
            sum_next = code_ext;
        end
        else if (add)
        begin
            sum_next = RESULT_W'(sum_reg + code_ext);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sum_reg <= RESULT_RESET;
        end
        else
        begin
            sum_reg <= sum_next;
        end
    end

    assign sum = sum_reg;

endmodule

// [conv_source.sv]
// behavioural model of the converter core that feeds finished conversions
// assumes a request pulse from the bench; emits one code after 0..3 idle cycles
`timescale 1ns/10ps

module conv_source
    import adc_fmt_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic req, // one conversion wanted
    input wire logic [SAMPLE_W-1:0] code_in, // code that conversion returns
    input wire logic [1:0] lag, // idle cycles before the code appears
    output conv_sample_t conv, // finished conversion, one-cycle valid
    output logic busy // conversion in flight
);
    logic [1:0] cnt_reg;
    logic [SAMPLE_W-1:0] held_reg;

    // outside a valid cycle the code toggles so stale data is never mistaken for a sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 2'h0;
            held_reg <= 12'h000;
            busy <= 1'b0;
            conv <= '0;
        end
        else if (req && !busy)
        begin
            cnt_reg <= lag;
            held_reg <= code_in;
            busy <= 1'b1;
            conv.valid <= 1'b0;
            conv.code <= ~conv.code;
        end
        else if (busy && cnt_reg == 2'h0)
        begin
            conv.valid <= 1'b1;
            conv.code <= held_reg;
            busy <= 1'b0;
        end
        else
        begin
            conv.valid <= 1'b0;
            conv.code <= ~conv.code;
            if (busy)
                cnt_reg <= cnt_reg - 2'h1;
        end
    end
endmodule

// [tb_adc_result_formatter.sv]
// self-checking bench for the result formatter: apb master, converter model,
// queue of expected published results checked on every result_update pulse
`timescale 1ns/10ps

module tb_adc_result_formatter
    import adc_fmt_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, result_update;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    conv_sample_t conv;
    result_pair_t result;
    logic req, busy, er;
    logic [SAMPLE_W-1:0] code_in;
    logic [1:0] lag;
    int failures, check_count;
    logic [15:0] exp_q[$];
    logic [SAMPLE_W-1:0] codes[5];

    adc_result_formatter u_adc_result_formatter (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv(conv), .result(result),
        .result_update(result_update));
    conv_source u_conv_source (.pclk(pclk), .presetn(presetn), .req(req), .code_in(code_in),
        .lag(lag), .conv(conv), .busy(busy));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // called just after a rising edge; leaves one idle edge so strobes never double-assign
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog may end a wait for pready
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(a, 1'b0, 32'h0);
        chk(nm, exp, rd);
    endtask

    task automatic send(input logic [SAMPLE_W-1:0] c);
        req <= 1'b1;
        code_in <= c;
        lag <= 2'($urandom % 4);
        @(posedge pclk);
        req <= 1'b0;
        do
        begin
            @(posedge pclk);
        end
        while (busy !== 1'b0);
    endtask

    // n samples; rnd draws a fresh code per sample, otherwise all equal c
    task automatic series(input int n, input logic lj, input logic [SAMPLE_W-1:0] c, input bit rnd);
        logic [SAMPLE_W-1:0] s[16];
        logic [15:0] exp;
        exp = 16'h0000;
        for (int i = 0; i < n; i++)
        begin
            s[i] = rnd ? 12'($urandom) : c;
            exp = exp + {4'h0, s[i]};
        end
        if (n == 1)
            exp = lj ? {s[0], 4'h0} : {4'h0, s[0]};
        exp_q.push_back(exp);
        for (int i = 0; i < n; i++)
            send(s[i]);
        @(posedge pclk);
        rd_chk(ADDR_RES_LOW, {24'h0, exp[7:0]}, "result low byte");
        rd_chk(ADDR_RES_HIGH, {24'h0, exp[15:8]}, "result high byte");
    endtask

    always @(posedge pclk)
    begin
        if (presetn === 1'b1 && result_update === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("result unexpected update", 32'h0, 32'h1);
            else
                chk("result", {16'h0, exp_q.pop_front()}, {16'h0, result});
        end
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        req = 1'b0;
        code_in = 12'h000;
        lag = 2'h0;
        void'($urandom(32'hB8DD49CB));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(ADDR_CTRL, {24'h0, CTRL_RESET}, "control reset");
        rd_chk(ADDR_CFG, {24'h0, CFG_RESET}, "config reset");
        rd_chk(ADDR_RES_LOW, 32'h0, "result low reset");
        apb(ADDR_RES_HIGH, 1'b1, 32'h5A);
        chk("result high write error", 32'h0, {31'h0, er});
        rd_chk(ADDR_RES_HIGH, 32'h0, "result high read only");
        apb(8'h14, 1'b0, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        $display("test registers done");
        codes = '{12'hFFF, 12'h800, 12'h7FF, 12'h000, 12'h5A3};
        for (int lj = 0; lj < 2; lj++)
        begin
            apb(ADDR_CTRL, 1'b1, 32'(lj << CTRL_LJST_BIT));
            rd_chk(ADDR_CTRL, 32'(lj << CTRL_LJST_BIT), "control readback");
            foreach (codes[i])
                series(1, lj[0], codes[i], i == 4);
        end
        $display("test single conversions done");
        apb(ADDR_CTRL, 1'b1, 32'h0); // keep right-justified while repeating
        for (int r = 1; r < 4; r++)
        begin
            apb(ADDR_CFG, 1'b1, {24'h0, CFG_RESET[7:3], r[1:0], CFG_RESET[0]});
            foreach (codes[i])
                series(4 << (r - 1), 1'b0, codes[i], i == 4);
        end
        $display("test repeat series done");
        apb(ADDR_CFG, 1'b1, {24'h0, CFG_RESET[7:3], RPT_FOUR, CFG_RESET[0]});
        send(12'hFFF);
        send(12'hFFF);
        rd_chk(ADDR_STATUS, 32'h2 | (32'h1 << STAT_ACTIVE_BIT), "status mid series");
        apb(ADDR_CFG, 1'b1, {24'h0, CFG_RESET[7:3], RPT_FOUR, CFG_RESET[0]});
        rd_chk(ADDR_STATUS, 32'h0, "status after restart");
        series(4, 1'b0, 12'h001, 1'b0); // partial series must not leak
        apb(ADDR_CTRL, 1'b1, 32'(1 << CTRL_LJST_BIT)); // deliberate breach
        rd_chk(ADDR_STATUS, 32'h1 << STAT_MISUSE_BIT, "status misuse flag");
        apb(ADDR_CTRL, 1'b1, 32'h0);
        apb(ADDR_CFG, 1'b1, {24'h0, CFG_RESET[7:3], RPT_ONE, CFG_RESET[0]});
        series(1, 1'b0, 12'h123, 1'b0);
        chk("pending results", 32'h0, 32'(exp_q.size()));
        $display("test series restart done");
        tally_and_finish();
    end
endmodule
